// ===== core/rsc_pkg.sv
// Package with constants and carrier types for the reset source and cause logic
// What this block does
// RL1 - Low-power brown-out holds reset, clears brown-out flag
// RL2 - Low-power detector enabled by config bit only
// RL3 - Pin reset off only when both bits zero
// RL4 - Enabled pin held low keeps device reset
// RL5 - Short low pin pulses are filtered out
// RL6 - Reset never drives the pin low
// RL7 - Disabled pin is input, pull-up software controlled
// RL8 - Watchdog timeout resets, updates timeout/powerdown bits
// RL9 - Reset instruction resets, clears its flag only
// RL10 - Stack fault resets only when enabled, sets flag
// RL11 - Programming exit behaves exactly like power-on
// RL12 - Power-up timer optionally delays after power-on/brown-out
// RL13 - Timer nominal 64 ms, enabled when bit clear
// RL14 - Start needs timer done, then pin released
// RL15 - Pin release after expiry: start 10 cycles later
// RL16 - Every reset updates flags; vector 0000h except wake
// RL17 - Power-on sets status 11, cause 00 110x
// RL18 - Pin reset awake clears only pin flag
// RL19 - Pin reset asleep: pin flag 0, timeout 1, powerdown 0
// RL20 - Interrupt wake resumes PC+1, vector 0004h if enabled
// RL21 - Power control register holds seven cause flags
// RL22 - Software sets power-on and brown-out flags again
// RL23 - Combined reset released synchronously to the clock
package rsc_pkg;

   // Clock rate and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int PWRUP_DELAY_MS = 64;
   localparam int PWRUP_DELAY_CYC = PWRUP_DELAY_MS * (CLK_HZ / 1000);
   localparam int PIN_RELEASE_CYC = 10;
   localparam int PIN_FILTER_CYC = 4;

   // Vectors
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;

   // Power control register bit positions
   localparam int PWRCTL_STACK_OVF_BIT = 7;
   localparam int PWRCTL_STACK_UNF_BIT = 6;
   localparam int PWRCTL_WDT_BIT = 4;
   localparam int PWRCTL_PIN_BIT = 3;
   localparam int PWRCTL_INSTR_BIT = 2;
   localparam int PWRCTL_POR_BIT = 1;
   localparam int PWRCTL_BROWNOUT_BIT = 0;

   // Power control value written on power-on (brown-out bit cleared too)
   localparam logic [7:0] PWRCTL_POR_VALUE = 8'h1c;
   // Bits forced on brown-out: pin and instruction flags set, rest kept or cleared
   localparam logic [7:0] PWRCTL_BROWNOUT_VALUE = 8'h0c;
   localparam logic [7:0] PWRCTL_WR_MASK = 8'hdf;

   // Register port
   localparam logic [1:0] ADDR_PWRCTL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_HOLD = 2'b00,
      SEQ_PWRUP = 2'b01,
      SEQ_PIN_WAIT = 2'b10,
      SEQ_RUN = 2'b11
   } rsc_seq_type;

   // Configuration word bits
   typedef struct packed {
      logic lp_brownout_en;
      logic ext_reset_pin_enable;
      logic low_voltage_program_enable;
      logic stack_fault_reset_enable;
      logic powerup_delay_enable_n;
   } rsc_cfg_type;

   // Reset and wake events from the core and detectors
   typedef struct packed {
      logic por;
      logic prog_exit;
      logic brownout;
      logic lp_brownout_low;
      logic wdt_timeout;
      logic wdt_in_sleep;
      logic reset_instr;
      logic stack_overflow;
      logic stack_underflow;
      logic irq_wake;
      logic sleeping;
      logic global_irq_enable;
   } rsc_evt_type;

   // Register access port
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rsc_reg_type;

   // All state of the block
   typedef struct packed {
      rsc_seq_type seq;
      logic [31:0] pwrup_cnt;
      logic pwrup_done;
      logic [3:0] rel_cnt;
      logic [3:0] filt_cnt;
      logic pin_low;
      logic sync_a;
      logic core_rst;
      logic [7:0] pwr_ctl;
      logic timeout_status_n;
      logic powerdown_status_n;
      logic [7:0] rdata;
      logic [14:0] vector;
      logic vector_load;
   } rsc_state_type;

endpackage : rsc_pkg

// ===== core/rsc_reset_cause.sv
// Reset source combiner, start-up sequencer and reset cause recorder
`timescale 1ns/1ps
module rsc_reset_cause #(
   parameter int PWRUP_CYC = rsc_pkg::PWRUP_DELAY_CYC,
   parameter int FILTER_CYC = rsc_pkg::PIN_FILTER_CYC
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Configuration and events
   input wire rsc_pkg::rsc_cfg_type i_cfg,
   input wire rsc_pkg::rsc_evt_type i_evt,
   // External reset pin and its pull-up
   input wire logic i_ext_reset_pin,
   input wire logic i_sw_pullup,
   output logic o_ext_reset_pin_out,
   output logic o_ext_reset_pin_oe,
   output logic o_ext_reset_pin_pullup,
   output logic o_gpio_in,
   // Register port
   input wire rsc_pkg::rsc_reg_type i_reg,
   output logic [7:0] o_rdata,
   // Core side
   output logic o_core_rst,
   output logic o_vector_load,
   output logic [14:0] o_vector
);
   import rsc_pkg::*;

   // Elaboration check on parameters
   if (PWRUP_CYC < 1 || FILTER_CYC < 1 || FILTER_CYC > 15) begin : g_bad
      $error("rsc_reset_cause: bad parameter");
   end

   rsc_state_type st;
   rsc_state_type next_st;
   logic pin_en;      // Pin reset function active
   logic lp_brownout_hit;   // Low-power detector reports low supply
   logic por_like;    // Power-on or programming exit
   logic pin_hold;    // Filtered pin held low
   logic any_async;   // Reset source that restarts the power-up timer
   logic stack_rst;   // Enabled stack fault

   // Pin enable decode and pin-side outputs
   always_comb begin
      pin_en = i_cfg.ext_reset_pin_enable | i_cfg.low_voltage_program_enable; // [RL3]
      lp_brownout_hit = i_cfg.lp_brownout_en & i_evt.lp_brownout_low; // [RL2]
      por_like = i_evt.por | i_evt.prog_exit; // [RL11]
      pin_hold = pin_en & st.pin_low; // [RL4]
      stack_rst = i_cfg.stack_fault_reset_enable
         & (i_evt.stack_overflow | i_evt.stack_underflow); // [RL10]
      any_async = por_like | i_evt.brownout | lp_brownout_hit;
   end

   // Pin never driven; pull-up forced only while pin reset enabled
   assign o_ext_reset_pin_out = 1'b0; // [RL6]
   assign o_ext_reset_pin_oe = 1'b0; // [RL6]
   assign o_ext_reset_pin_pullup = pin_en ? 1'b1 : i_sw_pullup; // [RL7]
   assign o_gpio_in = i_ext_reset_pin; // [RL7]
   assign o_rdata = st.rdata;
   assign o_core_rst = st.core_rst; // [RL23]
   assign o_vector = st.vector;
   assign o_vector_load = st.vector_load;

   // Next-state logic
   always_comb begin
      next_st = st;
      next_st.vector_load = 1'b0;
      next_st.rdata = 8'h00;
      // Pin noise filter: low must persist FILTER_CYC + 1 cycles
      if (i_ext_reset_pin) begin
         next_st.filt_cnt = 4'h0;
         next_st.pin_low = 1'b0;
      end else if (st.filt_cnt >= FILTER_CYC[3:0]) begin
         next_st.pin_low = 1'b1; // [RL5]
      end else begin
         next_st.filt_cnt = st.filt_cnt + 4'h1; // [RL5]
      end
      // Software writes to flags; hardware updates below win
      if (i_reg.wr && i_reg.addr == ADDR_PWRCTL) begin
         next_st.pwr_ctl = i_reg.wdata & PWRCTL_WR_MASK; // [RL22]
      end
      // Power-up timer runs independent of the pin
      if (!st.pwrup_done) begin
         if (st.pwrup_cnt >= PWRUP_CYC - 1) begin
            next_st.pwrup_done = 1'b1; // [RL13]
         end else begin
            next_st.pwrup_cnt = st.pwrup_cnt + 32'h1;
         end
      end
      // Sequencer
      case (st.seq)
         SEQ_HOLD: begin
            next_st.core_rst = 1'b1;
            next_st.seq = SEQ_PWRUP;
         end
         SEQ_PWRUP: begin
            // Wait for timer if enabled (bit clear)
            if (st.pwrup_done || i_cfg.powerup_delay_enable_n) begin
               next_st.seq = SEQ_PIN_WAIT; // [RL12] [RL14]
               next_st.rel_cnt = 4'h0;
            end
         end
         SEQ_PIN_WAIT: begin
            if (pin_hold) begin
               next_st.rel_cnt = 4'h0; // [RL14]
            end else if (st.rel_cnt >= PIN_RELEASE_CYC[3:0] - 4'h1) begin
               next_st.seq = SEQ_RUN; // [RL15]
               next_st.core_rst = 1'b0;
               next_st.vector = RESET_VECTOR; // [RL16]
               next_st.vector_load = 1'b1;
            end else begin
               next_st.rel_cnt = st.rel_cnt + 4'h1; // [RL15]
            end
         end
         SEQ_RUN: begin
            // Interrupt wake from sleep: PC+1, then vector if enabled
            if (i_evt.irq_wake && i_evt.sleeping) begin
               next_st.timeout_status_n = 1'b1; // [RL20]
               next_st.powerdown_status_n = 1'b0;
               if (i_evt.global_irq_enable) begin
                  next_st.vector = IRQ_VECTOR; // [RL20]
                  next_st.vector_load = 1'b1;
               end
            end
            if (i_evt.wdt_timeout && i_evt.sleeping) begin
               next_st.timeout_status_n = 1'b0; // Watchdog wake
               next_st.powerdown_status_n = 1'b0;
            end
         end
         default: next_st.seq = SEQ_HOLD;
      endcase
      // Synchronous reset sources, recorded then sequenced
      if (pin_hold && st.seq == SEQ_RUN) begin
         next_st.pwr_ctl[PWRCTL_PIN_BIT] = 1'b0; // [RL18]
         if (i_evt.sleeping) begin
            next_st.timeout_status_n = 1'b1; // [RL19]
            next_st.powerdown_status_n = 1'b0;
         end
         next_st.core_rst = 1'b1; // [RL4]
         next_st.seq = SEQ_PIN_WAIT;
         next_st.rel_cnt = 4'h0;
      end
      if (i_evt.wdt_timeout && !i_evt.sleeping) begin
         next_st.pwr_ctl[PWRCTL_WDT_BIT] = 1'b0; // [RL8]
         next_st.timeout_status_n = 1'b0; // [RL8]
         next_st.core_rst = 1'b1;
         next_st.seq = SEQ_HOLD;
      end
      if (i_evt.reset_instr) begin
         next_st.pwr_ctl[PWRCTL_INSTR_BIT] = 1'b0; // [RL9]
         next_st.core_rst = 1'b1;
         next_st.seq = SEQ_HOLD;
      end
      if (stack_rst) begin
         if (i_evt.stack_overflow) next_st.pwr_ctl[PWRCTL_STACK_OVF_BIT] = 1'b1; // [RL10]
         if (i_evt.stack_underflow) next_st.pwr_ctl[PWRCTL_STACK_UNF_BIT] = 1'b1; // [RL10]
         next_st.core_rst = 1'b1;
         next_st.seq = SEQ_HOLD;
      end
      // Brown-out from either detector: restarts timer
      // Watchdog and power-on flags kept, stack flags cleared
      if (i_evt.brownout || lp_brownout_hit) begin
         next_st.pwr_ctl = (st.pwr_ctl & 8'h12) | PWRCTL_BROWNOUT_VALUE; // [RL1] [RL16]
         next_st.pwr_ctl[PWRCTL_BROWNOUT_BIT] = 1'b0; // [RL1]
         next_st.timeout_status_n = 1'b1;
         next_st.powerdown_status_n = 1'b1;
      end
      // Power-on or programming exit
      if (por_like) begin
         next_st.pwr_ctl = PWRCTL_POR_VALUE; // [RL17] [RL11]
         next_st.timeout_status_n = 1'b1; // [RL17]
         next_st.powerdown_status_n = 1'b1;
      end
      if (any_async) begin
         next_st.core_rst = 1'b1; // [RL1]
         next_st.seq = SEQ_HOLD;
         next_st.pwrup_cnt = 32'h0; // [RL12]
         next_st.pwrup_done = 1'b0;
      end
      // Read data, one cycle after strobe
      if (i_reg.rd) begin
         case (i_reg.addr)
            ADDR_PWRCTL: next_st.rdata = st.pwr_ctl; // [RL21]
            ADDR_STATUS: next_st.rdata = {6'h00, st.timeout_status_n,
                                          st.powerdown_status_n};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   // State register; reset leaves cause as after power-on
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st <= '0;
         st.seq <= SEQ_HOLD;
         st.core_rst <= 1'b1;
         st.pwr_ctl <= PWRCTL_POR_VALUE; // [RL17]
         st.timeout_status_n <= 1'b1;
         st.powerdown_status_n <= 1'b1;
      end else begin
         st <= next_st; // [RL23]
      end
   end

endmodule : rsc_reset_cause

// ===== verif/rsc_pin_model.sv
// Model of the external reset pin with its weak pull-up
`timescale 1ns/1ps
module rsc_pin_model (
   // Press request from the bench
   input wire logic i_press,
   // Drive and enable from the design
   input wire logic i_drive,
   input wire logic i_oe,
   // Resolved pin level
   output logic o_pin
);
   // Pull-up holds the pin high unless pressed or driven
   assign o_pin = i_press ? 1'b0 : (i_oe ? i_drive : 1'b1);
endmodule : rsc_pin_model

// ===== verif/rsc_reset_cause_props.sv
// Assertion checker for the reset source and cause logic
`timescale 1ns/1ps
module rsc_reset_cause_props import rsc_pkg::*; #(
   parameter int PWRUP_CYC = 20,
   parameter int FILTER_CYC = 4
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Inputs watched
   input wire rsc_pkg::rsc_cfg_type i_cfg,
   input wire rsc_pkg::rsc_evt_type i_evt,
   input wire logic i_ext_reset_pin,
   input wire logic i_sw_pullup,
   input wire rsc_pkg::rsc_reg_type i_reg,
   // Outputs watched
   input wire logic o_ext_reset_pin_oe,
   input wire logic o_ext_reset_pin_pullup,
   input wire logic [7:0] o_rdata,
   input wire logic o_core_rst,
   input wire logic o_vector_load,
   input wire logic [14:0] o_vector
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Pin reset function enabled
   wire logic pin_en = i_cfg.ext_reset_pin_enable | i_cfg.low_voltage_program_enable;
   a_pin_undriven: assert property (o_ext_reset_pin_oe == 1'b0)
      else $error("reset pin driven");
   a_pullup_follow: assert property (o_ext_reset_pin_pullup == (pin_en | i_sw_pullup))
      else $error("pull-up wrong");
   a_por_holds: assert property (i_evt.por || i_evt.prog_exit |=> o_core_rst)
      else $error("power-on did not hold core");
   a_lp_brownout_hold: assert property (i_evt.lp_brownout_low && i_cfg.lp_brownout_en
      |=> o_core_rst)
      else $error("low-power brown-out did not hold core");
   a_pin_holds: assert property ((pin_en && !i_ext_reset_pin)[*8] |-> o_core_rst)
      else $error("low pin did not hold core");
   a_release_vec: assert property ($fell(o_core_rst) |-> o_vector_load && o_vector == 15'h0000)
      else $error("release without start vector");
   a_pin_ten: assert property ($fell(o_core_rst) && pin_en |-> $past(i_ext_reset_pin, 10))
      else $error("release too soon after pin");
   a_rdata_idle: assert property (!i_reg.rd || i_reg.addr[1] |=> o_rdata == 8'h00)
      else $error("read data not idle");
   a_wake_vec: assert property (i_evt.irq_wake && i_evt.sleeping && i_evt.global_irq_enable
      && !o_core_rst |-> ##[1:3] (o_vector_load && o_vector == 15'h0004))
      else $error("wake vector missing");
   // Main scenarios reached
   c_release: cover property ($fell(o_core_rst));
   c_wake: cover property (o_vector_load && o_vector == 15'h0004);
   c_lp_brownout: cover property (i_evt.lp_brownout_low && i_cfg.lp_brownout_en);
endmodule : rsc_reset_cause_props
bind rsc_reset_cause rsc_reset_cause_props #(.PWRUP_CYC(PWRUP_CYC), .FILTER_CYC(FILTER_CYC))
   u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_evt(i_evt),
   .i_ext_reset_pin(i_ext_reset_pin), .i_sw_pullup(i_sw_pullup), .i_reg(i_reg),
   .o_ext_reset_pin_oe(o_ext_reset_pin_oe), .o_ext_reset_pin_pullup(o_ext_reset_pin_pullup),
   .o_rdata(o_rdata), .o_core_rst(o_core_rst), .o_vector_load(o_vector_load),
   .o_vector(o_vector));

// ===== verif/rsc_reset_cause_tb.sv
// Self-checking bench for the reset source and cause logic
`timescale 1ns/1ps
module rsc_reset_cause_tb;
   import rsc_pkg::*;
   logic clk = 0, rst = 1, press = 0, swp = 0, pin, drv, oe, crst, vld, rd_d = 0;
   logic [4:0] cfg = 5'h1a;
   logic [11:0] evt = '0;
   rsc_reg_type rg = '0;
   logic [7:0] rdata;
   logic [14:0] vec;
   logic pup, gin;
   int err_total = 0, tests_run = 0, seed = 18160, n;
   logic [7:0] exp_q[$];
   // Event table: reset source, cause and status after it
   logic [11:0] ev[8] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h020, 12'h010, 12'h008, 12'h080};
   logic [7:0] ep[8] = '{8'h1c, 8'h1c, 8'h1e, 8'h1e, 8'h1b, 8'h9f, 8'h5f, 8'h0f};
   logic [7:0] es[8] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
   // Cases that must not reset: config, event, press length
   logic [4:0] nc[4] = '{5'h0b, 5'h19, 5'h13, 5'h1b};
   logic [11:0] ne[4] = '{12'h100, 12'h010, 12'h000, 12'h000};
   int np[4] = '{0, 0, 12, 2};
   rsc_pin_model pm (.i_press(press), .i_drive(drv), .i_oe(oe), .o_pin(pin));
   rsc_reset_cause #(.PWRUP_CYC(20), .FILTER_CYC(4)) dut (.i_ref_clk(clk), .i_rst(rst),
      .i_cfg(cfg), .i_evt(evt), .i_ext_reset_pin(pin), .i_sw_pullup(swp),
      .o_ext_reset_pin_out(drv), .o_ext_reset_pin_oe(oe), .o_ext_reset_pin_pullup(pup),
      .o_gpio_in(gin), .i_reg(rg), .o_rdata(rdata), .o_core_rst(crst),
      .o_vector_load(vld), .o_vector(vec));
   initial forever #10 clk = ~clk;
   // Random software pull-up level
   always @(posedge clk) swp <= 1'($random(seed));
   task automatic check_val(input logic [14:0] got, input logic [14:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check_val
   // Read data stand in the cycle after the strobe
   always @(posedge clk) rd_d <= rg.rd;
   always @(negedge clk) if (rd_d) check_val(15'(rdata), 15'(exp_q.pop_front()));
   // Pull-up forced while pin reset enabled, else software level; pin readable
   always @(negedge clk) if (!rst) check_val(15'(pup), 15'(cfg[3] | cfg[2] | swp));
   always @(negedge clk) if (!rst) check_val(15'(gin), 15'(pin));
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk) rg <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) rg <= '0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk) rg <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) rg <= '0;
   endtask : rd
   task automatic pulse(input logic [11:0] m);
      @(posedge clk) evt <= evt | m;
      @(posedge clk) evt <= evt & ~m;
   endtask : pulse
   task automatic push_pin(input int k);
      @(posedge clk) press <= 1'b1;
      repeat (k) @(posedge clk);
      press <= 1'b0;
   endtask : push_pin
   // Cycles until the core runs, bounded
   task automatic wait_run(output int c);
      c = 0;
      do begin @(negedge clk); c++; end while (crst !== 1'b0 && c < 200);
      check_val(15'(crst), 15'h0);
   endtask : wait_run
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // Hang guard
   initial begin
      #200us;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_PWRCTL, 8'h1c);
      rd(ADDR_STATUS, 8'h03);
      wait_run(n);
      check_val(15'(n >= 20), 15'h1);
      cfg <= 5'h1b;
      pulse(12'h800);
      wait_run(n);
      check_val(15'(n < 20), 15'h1);
      $display("test start-up done");
      wr(2'h2, 8'($random(seed)));
      rd(2'h2, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_PWRCTL, 8'h1f);
         pulse(ev[i]);
         wait_run(n);
         rd(ADDR_PWRCTL, ep[i]);
         rd(ADDR_STATUS, es[i]);
      end
      $display("test cause table done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) cfg <= nc[i];
         pulse(ne[i]);
         if (np[i] > 0) push_pin(np[i]);
         repeat (20) @(negedge clk);
         check_val(15'(crst), 15'h0);
      end
      $display("test no reset done");
      @(posedge clk) cfg <= 5'h17;
      wr(ADDR_PWRCTL, 8'h1f);
      push_pin(10);
      wait_run(n);
      rd(ADDR_PWRCTL, 8'h17);
      rd(ADDR_STATUS, 8'h01);
      @(posedge clk) evt[1] <= 1'b1;
      push_pin(10);
      wait_run(n);
      rd(ADDR_STATUS, 8'h02);
      $display("test pin reset done");
      @(posedge clk) evt[0] <= 1'b1;
      pulse(12'h004);
      n = 0;
      while (vld !== 1'b1 && n < 10) begin @(negedge clk); n++; end
      check_val(vec, 15'h0004);
      rd(ADDR_STATUS, 8'h02);
      @(posedge clk) evt[1] <= 1'b0;
      $display("test wake done");
      repeat (3) @(negedge clk);
      tally_and_finish();
   end
endmodule : rsc_reset_cause_tb
